// >>> lgs_pkg.sv
// constants and types shared by the graphics display core
package lgs_pkg;
    // display geometry
    localparam int          COLS        = 112;
    localparam int          ROWS        = 80;
    localparam int          BANDS       = 10;
    localparam int          ADDR_W      = 11;
    localparam logic [6:0]  COL_LAST    = 7'h6f;
    // register offsets (byte addresses)
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_DATA    = 8'h04;
    localparam logic [7:0]  OFS_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_CONFIG  = 8'h0c;
    // command word: opcode above an 11-bit argument
    localparam int          CMD_OP_LSB  = 12;
    localparam logic [3:0]  OP_ADDR     = 4'h1;
    localparam logic [3:0]  OP_ENTRY    = 4'h2;
    localparam logic [3:0]  OP_DISP     = 4'h3;
    localparam logic [3:0]  OP_LINES    = 4'h4;
    localparam logic [3:0]  OP_POWER    = 4'h5;
    localparam logic [3:0]  OP_CONTRAST = 4'h6;
    // argument bit positions
    localparam int          ENTRY_UP    = 0;
    localparam int          ENTRY_RDM   = 1;
    localparam int          DISP_ON     = 0;
    localparam int          DISP_STBY   = 1;
    localparam int          DISP_SLEEP  = 2;
    localparam int          DISP_SGS    = 3;
    localparam int          DISP_CMS    = 4;
    localparam int          DISP_EXTCLK = 5;
    localparam int          PWR_BOOST   = 0;
    localparam int          PWR_BIAS    = 2;
    localparam int          PWR_FOLOFF  = 5;
    // limits and reset values
    localparam logic [1:0]  BOOST_MAX   = 2'h2;
    localparam logic [2:0]  BIAS_MAX    = 3'h6;
    localparam logic [6:0]  RST_LINES   = 7'h50;
    localparam logic [1:0]  RST_BOOST   = 2'h0;
    localparam logic [2:0]  RST_BIAS    = 3'h0;
    localparam logic [5:0]  RST_CONTRAST = 6'h00;
    // timing and buffering
    localparam int          ROW_CYCLES  = 128;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          FIFO_WIDTH  = 19;

    typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_LOAD} lgs_rd_t;
endpackage

// >>> lgs_display_core.sv
// graphics display core: bus slave, address counter, ram, write fifo, row scan
`timescale 1ns/1ps

module lgs_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic [AW:0]      next_wp;
    logic [AW:0]      next_rp;

    always_comb begin
        in_ready  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
        out_valid = (wp != rp);
        out_data  = mem[rp[AW-1:0]];
        next_wp   = (in_valid && in_ready) ? wp + 1'b1 : wp;
        next_rp   = (out_valid && out_ready) ? rp + 1'b1 : rp;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    always_ff @(posedge hclk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

module lgs_display_core #(
    parameter int ROW_CYCLES = lgs_pkg::ROW_CYCLES,
    parameter int FIFO_DEPTH = lgs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // display drivers
    output logic [79:0]        row_select,
    output logic [79:0]        row_active,
    output logic [111:0]       column_data,
    // drive level and clock controls
    output logic [1:0]         boost_level,
    output logic [2:0]         bias_select,
    output logic               follower_off,
    output logic [5:0]         contrast,
    output logic               osc_enable,
    output logic               clock_external
);
    if (ROW_CYCLES < lgs_pkg::COLS + 2 || ROW_CYCLES > 255) begin : g_bad_row
        $error("row period must hold the shift and the latch");
    end

    localparam int RAM_WORDS = lgs_pkg::COLS * lgs_pkg::BANDS;
    localparam logic [7:0] PH_SHIFT_END = 8'(lgs_pkg::COLS);
    localparam logic [7:0] PH_LATCH = 8'(lgs_pkg::COLS + 1);
    localparam logic [7:0] PH_LAST = 8'(ROW_CYCLES - 1);

    // byte address to ram word index; valid only for real columns and bands
    function automatic logic [10:0] ram_index(input logic [10:0] a);
        ram_index = 11'(a[10:7]) * 11'(lgs_pkg::COLS) + 11'(a[6:0]);
    endfunction

    function automatic logic addr_ok(input logic [10:0] a);
        addr_ok = (a[6:0] <= lgs_pkg::COL_LAST) && (a[10:7] < 4'(lgs_pkg::BANDS));
    endfunction

    // bus and control state
    logic                  dp_valid;
    logic                  dp_write;
    logic [7:0]            dp_ofs;
    lgs_pkg::lgs_rd_t      rd_state;
    logic [7:0]            dtr;
    logic [10:0]           ram_address_counter;
    logic                  dir_up;
    logic                  read_advance_control;
    logic                  disp_on;
    logic                  standby;
    logic                  sleep;
    logic                  segment_direction_select;
    logic                  common_direction_select;
    logic [6:0]            lines;
    logic                  next_dp_valid;
    logic                  next_dp_write;
    logic [7:0]            next_dp_ofs;
    lgs_pkg::lgs_rd_t      next_rd_state;
    logic [31:0]           next_hrdata;
    logic [7:0]            next_dtr;
    logic [10:0]           next_ac;
    logic                  next_dir_up;
    logic                  next_rdm;
    logic                  next_disp_on;
    logic                  next_standby;
    logic                  next_sleep;
    logic                  next_sgs;
    logic                  next_cms;
    logic                  next_extclk;
    logic [6:0]            next_lines;
    logic [1:0]            next_boost;
    logic [2:0]            next_bias;
    logic                  next_foloff;
    logic [5:0]            next_contrast;

    // fifo and ram port
    logic                  fifo_in_valid;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    logic [18:0]           fifo_out_data;
    logic [7:0]            graphics_ram [RAM_WORDS];
    logic [7:0]            ram_q;
    logic [10:0]           ram_rd_addr;
    logic                  ram_rd_en;
    logic                  refresh_use;
    logic                  host_fetch;

    // scan state
    logic [7:0]            phase;
    logic [6:0]            row;
    logic [111:0]          shifter;
    logic [111:0]          seg_latch;
    logic [6:0]            latched_row;
    logic [7:0]            next_phase;
    logic [6:0]            next_row;
    logic [111:0]          next_shifter;
    logic [111:0]          next_seg_latch;
    logic [6:0]            next_latched_row;
    logic [79:0]           next_row_select;
    logic [79:0]           next_row_active;
    logic [111:0]          next_column_data;
    logic [6:0]            refresh_col;
    logic                  drive_off;

    logic                  ap_take;
    logic [3:0]            cmd_op;
    logic [10:0]           cmd_arg;

    always_comb begin
        ap_take = hsel && htrans[1] && hready;
        cmd_op  = hwdata[lgs_pkg::CMD_OP_LSB +: 4];
        cmd_arg = hwdata[lgs_pkg::ADDR_W-1:0];
        drive_off = !disp_on || standby || sleep;
        osc_enable = !standby && !clock_external;
        refresh_use = (phase < PH_SHIFT_END);
        host_fetch = (rd_state == lgs_pkg::RD_FETCH) && !fifo_out_valid && !refresh_use;
        fifo_out_ready = !refresh_use;
        fifo_in_valid = dp_valid && dp_write && (dp_ofs == lgs_pkg::OFS_DATA);
        refresh_col = segment_direction_select ? lgs_pkg::COL_LAST - 7'(phase)
                                               : 7'(phase);
        ram_rd_addr = refresh_use ? {row[6:3], refresh_col} : ram_address_counter;
        ram_rd_en = refresh_use || host_fetch;
        hresp = 1'b0;
        if (!dp_valid) begin
            hreadyout = 1'b1;
        end else if (fifo_in_valid) begin
            hreadyout = fifo_in_ready;
        end else if (!dp_write && dp_ofs == lgs_pkg::OFS_DATA) begin
            hreadyout = (rd_state == lgs_pkg::RD_LOAD);
        end else begin
            hreadyout = 1'b1;
        end
    end

    // bus slave, address counter and control settings
    always_comb begin
        next_dp_valid = dp_valid;
        next_dp_write = dp_write;
        next_dp_ofs   = dp_ofs;
        next_rd_state = rd_state;
        next_hrdata   = hrdata;
        next_dtr      = dtr;
        next_ac       = ram_address_counter;
        next_dir_up   = dir_up;
        next_rdm      = read_advance_control;
        next_disp_on  = disp_on;
        next_standby  = standby;
        next_sleep    = sleep;
        next_sgs      = segment_direction_select;
        next_cms      = common_direction_select;
        next_extclk   = clock_external;
        next_lines    = lines;
        next_boost    = boost_level;
        next_bias     = bias_select;
        next_foloff   = follower_off;
        next_contrast = contrast;
        if (dp_valid && hreadyout) begin
            next_dp_valid = 1'b0;
        end
        if (fifo_in_valid && fifo_in_ready) begin
            next_ac = dir_up ? ram_address_counter + 11'h001
                             : ram_address_counter - 11'h001;
        end
        if (dp_valid && dp_write && dp_ofs == lgs_pkg::OFS_CMD) begin
            case (cmd_op)
                lgs_pkg::OP_ADDR: next_ac = cmd_arg;
                lgs_pkg::OP_ENTRY: begin
                    next_dir_up = cmd_arg[lgs_pkg::ENTRY_UP];
                    next_rdm = cmd_arg[lgs_pkg::ENTRY_RDM];
                end
                lgs_pkg::OP_DISP: begin
                    next_disp_on = cmd_arg[lgs_pkg::DISP_ON];
                    next_standby = cmd_arg[lgs_pkg::DISP_STBY];
                    next_sleep   = cmd_arg[lgs_pkg::DISP_SLEEP];
                    next_sgs     = cmd_arg[lgs_pkg::DISP_SGS];
                    next_cms     = cmd_arg[lgs_pkg::DISP_CMS];
                    next_extclk  = cmd_arg[lgs_pkg::DISP_EXTCLK];
                end
                lgs_pkg::OP_LINES: begin
                    if (cmd_arg[6:0] != 7'h00 && cmd_arg[6:0] <= 7'(lgs_pkg::ROWS)) begin
                        next_lines = cmd_arg[6:0];
                    end
                end
                lgs_pkg::OP_POWER: begin
                    if (cmd_arg[lgs_pkg::PWR_BOOST +: 2] <= lgs_pkg::BOOST_MAX) begin
                        next_boost = cmd_arg[lgs_pkg::PWR_BOOST +: 2];
                    end
                    if (cmd_arg[lgs_pkg::PWR_BIAS +: 3] <= lgs_pkg::BIAS_MAX) begin
                        next_bias = cmd_arg[lgs_pkg::PWR_BIAS +: 3];
                    end
                    next_foloff = cmd_arg[lgs_pkg::PWR_FOLOFF];
                end
                lgs_pkg::OP_CONTRAST: next_contrast = cmd_arg[5:0];
                default: ;
            endcase
        end
        case (rd_state)
            lgs_pkg::RD_FETCH: begin
                if (host_fetch) begin
                    next_rd_state = lgs_pkg::RD_LOAD;
                end
            end
            lgs_pkg::RD_LOAD: begin
                next_dtr = ram_q;
                if (read_advance_control) begin
                    next_ac = dir_up ? ram_address_counter + 11'h001
                                     : ram_address_counter - 11'h001;
                end
                next_rd_state = lgs_pkg::RD_IDLE;
            end
            default: ;
        endcase
        if (ap_take) begin
            next_dp_valid = 1'b1;
            next_dp_write = hwrite;
            next_dp_ofs   = haddr[7:0];
            next_hrdata   = 32'h0000_0000;
            if (!hwrite) begin
                if (haddr[7:0] == lgs_pkg::OFS_DATA) begin
                    next_hrdata   = {24'h00_0000, dtr};
                    next_rd_state = lgs_pkg::RD_FETCH;
                end else if (haddr[7:0] == lgs_pkg::OFS_STATUS) begin
                    next_hrdata = {6'h00, row, sleep, standby, disp_on, 4'h0,
                                   !fifo_out_valid, ram_address_counter};
                end else if (haddr[7:0] == lgs_pkg::OFS_CONFIG) begin
                    next_hrdata = {8'h00, clock_external, common_direction_select,
                                   segment_direction_select, read_advance_control, dir_up,
                                   contrast, follower_off, bias_select, boost_level, lines};
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid                 <= 1'b0;
            dp_write                 <= 1'b0;
            dp_ofs                   <= 8'h00;
            rd_state                 <= lgs_pkg::RD_IDLE;
            hrdata                   <= 32'h0000_0000;
            dtr                      <= 8'h00;
            ram_address_counter      <= 11'h000;
            dir_up                   <= 1'b1;
            read_advance_control     <= 1'b1;
            disp_on                  <= 1'b0;
            standby                  <= 1'b0;
            sleep                    <= 1'b0;
            segment_direction_select <= 1'b0;
            common_direction_select  <= 1'b0;
            clock_external           <= 1'b0;
            lines                    <= lgs_pkg::RST_LINES;
            boost_level              <= lgs_pkg::RST_BOOST;
            bias_select              <= lgs_pkg::RST_BIAS;
            follower_off             <= 1'b0;
            contrast                 <= lgs_pkg::RST_CONTRAST;
        end else begin
            dp_valid                 <= next_dp_valid;
            dp_write                 <= next_dp_write;
            dp_ofs                   <= next_dp_ofs;
            rd_state                 <= next_rd_state;
            hrdata                   <= next_hrdata;
            dtr                      <= next_dtr;
            ram_address_counter      <= next_ac;
            dir_up                   <= next_dir_up;
            read_advance_control     <= next_rdm;
            disp_on                  <= next_disp_on;
            standby                  <= next_standby;
            sleep                    <= next_sleep;
            segment_direction_select <= next_sgs;
            common_direction_select  <= next_cms;
            clock_external           <= next_extclk;
            lines                    <= next_lines;
            boost_level              <= next_boost;
            bias_select              <= next_bias;
            follower_off             <= next_foloff;
            contrast                 <= next_contrast;
        end
    end

    // written bytes carry their own address so the counter can run ahead
    lgs_fifo #(
        .WIDTH (lgs_pkg::FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({ram_address_counter, hwdata[7:0]}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // single-port ram: scan first, then queued writes, then host fetch
    always_ff @(posedge hclk) begin
        if (fifo_out_valid && fifo_out_ready && addr_ok(fifo_out_data[18:8])) begin
            graphics_ram[ram_index(fifo_out_data[18:8])] <= fifo_out_data[7:0];
        end
        if (ram_rd_en) begin
            ram_q <= addr_ok(ram_rd_addr) ? graphics_ram[ram_index(ram_rd_addr)] : 8'h00;
        end
    end

    // row scan: shift, latch, drive
    always_comb begin
        next_phase       = (phase == PH_LAST) ? 8'h00 : phase + 8'h01;
        next_row         = row;
        next_shifter     = shifter;
        next_seg_latch   = seg_latch;
        next_latched_row = latched_row;
        if (phase == PH_LAST) begin
            next_row = (row + 7'h01 >= lines) ? 7'h00 : row + 7'h01;
        end
        if (phase >= 8'h01 && phase <= PH_SHIFT_END) begin
            next_shifter = {ram_q[row[2:0]], shifter[111:1]};
        end
        if (phase == PH_LATCH) begin
            next_seg_latch   = shifter;
            next_latched_row = row;
        end
        next_row_select  = '0;
        next_row_active  = '0;
        for (int i = 0; i < lgs_pkg::ROWS; i++) begin
            if (7'(i) < lines) begin
                next_row_active[common_direction_select ? lgs_pkg::ROWS - 1 - i : i] = 1'b1;
            end
        end
        if (latched_row < lines) begin
            next_row_select[common_direction_select ? 7'(lgs_pkg::ROWS - 1) - latched_row
                                                    : latched_row] = 1'b1;
        end
        next_column_data = seg_latch;
        if (drive_off) begin
            next_row_select  = '0;
            next_row_active  = '0;
            next_column_data = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase       <= 8'h00;
            row         <= 7'h00;
            shifter     <= '0;
            seg_latch   <= '0;
            latched_row <= 7'h00;
            row_select  <= '0;
            row_active  <= '0;
            column_data <= '0;
        end else begin
            phase       <= next_phase;
            row         <= next_row;
            shifter     <= next_shifter;
            seg_latch   <= next_seg_latch;
            latched_row <= next_latched_row;
            row_select  <= next_row_select;
            row_active  <= next_row_active;
            column_data <= next_column_data;
        end
    end
endmodule

// >>> lgs_properties.sv
// checker of bus timing and driver relations for the display core
`timescale 1ns/1ps
module lgs_properties (
    // clock, reset and bus
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hsel,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire logic         hresp,
    // drivers and levels
    input wire logic [79:0]  row_select,
    input wire logic [79:0]  row_active,
    input wire logic [111:0] column_data,
    input wire logic [1:0]   boost_level,
    input wire logic [2:0]   bias_select,
    input wire logic [5:0]   contrast,
    input wire logic         osc_enable,
    input wire logic         clock_external
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic go;
    logic [12:0] stall;
    assign go = hsel && htrans[1] && hready;
    // length of the current wait; a read may sit behind a full write queue
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall <= 13'h0000;
        end else begin
            stall <= hreadyout ? 13'h0000 : stall + 13'h0001;
        end
    end
    a_cmd_nowait: assert property (go && hwrite && haddr[7:0] == 8'h00 |=> hreadyout)
        else $error("command write stalled");
    a_read_wait: assert property (go && !hwrite && haddr[7:0] == 8'h04 |=> !hreadyout)
        else $error("data read did not wait");
    a_stall_bound: assert property (stall < 13'h1200)
        else $error("bus wait too long");
    a_row_onehot: assert property ($onehot0(row_select))
        else $error("several rows selected");
    a_row_masked: assert property ((row_select & ~row_active) == 80'h0)
        else $error("unselected row driven");
    a_off_ground: assert property (row_active == 80'h0 |-> column_data == 112'h0)
        else $error("columns driven while off");
    a_osc_ext: assert property (clock_external |-> !osc_enable)
        else $error("oscillator runs on external clock");
    a_boost_range: assert property (boost_level <= 2'h2)
        else $error("boost level out of range");
    a_bias_range: assert property (bias_select <= 3'h6)
        else $error("bias out of range");
    a_contrast_cause: assert property ($changed(contrast) |->
        $past(go && hwrite && haddr[7:0] == 8'h00, 2)) else $error("contrast moved alone");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
endmodule

bind lgs_display_core lgs_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .row_select, .row_active, .column_data,
    .boost_level, .bias_select, .contrast, .osc_enable, .clock_external);

// >>> lgs_host_model.sv
// host processor model: single-word ahb-lite transfers
`timescale 1ns/1ps
module lgs_host_model (
    // bus
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    end
    // request held until hready seen high at an edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h0, a, 2'b10, w, 3'b010};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the display core
`timescale 1ns/1ps
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, follower_off, osc_enable;
    logic clock_external;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, boost_level;
    logic [2:0] hsize, bias_select;
    logic [5:0] contrast;
    logic [79:0] row_select, row_active;
    logic [111:0] column_data;
    logic [10:0] offs [3] = '{11'h03, 11'h05, 11'h00};
    int fail_count = 0;
    int checked = 0;
    initial begin
        hclk = 0;
        forever #50 hclk = ~hclk;
    end
    lgs_host_model HOST (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata);
    lgs_display_core #(.ROW_CYCLES(114)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .row_select, .row_active, .column_data, .boost_level, .bias_select,
        .follower_off, .contrast, .osc_enable, .clock_external);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        HOST.xfer(a, 1'b1, d, rd);
    endtask
    task automatic rdd(input logic [7:0] a);
        HOST.xfer(a, 1'b0, 32'h0, rd);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [10:0] arg);
        wr(lgs_pkg::OFS_CMD, {16'h0, op, 1'b0, arg});
    endtask
    task automatic wait_row(input int k);
        int n = 0;
        while (row_select[k] !== 1'b1 && n < 20000) begin
            @(negedge hclk);
            n++;
        end
        if (n >= 20000) fail_count++;
    endtask
    task automatic close_out();
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #9000000;
        fail_count++;
        close_out();
    end
    initial begin
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check("levels", {boost_level, bias_select, follower_off, contrast, osc_enable,
            clock_external}, 32'h2);
        rdd(lgs_pkg::OFS_CONFIG);
        check("config", rd, 32'h0018_0050);
        cmd(lgs_pkg::OP_POWER, 11'h03a);
        cmd(lgs_pkg::OP_POWER, 11'h01f);
        cmd(lgs_pkg::OP_CONTRAST, 11'h03f);
        @(negedge hclk);
        check("power", {boost_level, bias_select, follower_off, contrast}, 32'hb3f);
        cmd(lgs_pkg::OP_DISP, 11'h020);
        @(negedge hclk);
        check("clock", {osc_enable, clock_external}, 32'h1);
        cmd(lgs_pkg::OP_ADDR, 11'h000);
        for (int i = 0; i < 112; i++) wr(lgs_pkg::OFS_DATA, (i < 40) ? i : 0);
        rdd(lgs_pkg::OFS_STATUS);
        check("count up", rd[10:0], 11'h070);
        cmd(lgs_pkg::OP_ENTRY, 11'h002);
        cmd(lgs_pkg::OP_ADDR, 11'h085);
        wr(lgs_pkg::OFS_DATA, 32'ha5);
        rdd(lgs_pkg::OFS_STATUS);
        check("count down", rd[10:0], 11'h084);
        cmd(lgs_pkg::OP_ENTRY, 11'h003);
        cmd(lgs_pkg::OP_ADDR, 11'h005);
        repeat (3) begin
            rdd(lgs_pkg::OFS_DATA);
        end
        check("read next", rd[7:0], 8'h06);
        cmd(lgs_pkg::OP_ENTRY, 11'h001);
        cmd(lgs_pkg::OP_ADDR, 11'h085);
        // first read after an address set is stale and dropped
        rdd(lgs_pkg::OFS_DATA);
        repeat (3) begin
            rdd(lgs_pkg::OFS_DATA);
            check("read hold", rd[7:0], 8'ha5);
        end
        wr(8'h10, 32'hffff);
        rdd(8'h10);
        check("unmapped", rd, 32'h0);
        cmd(lgs_pkg::OP_LINES, 11'h008);
        cmd(lgs_pkg::OP_DISP, 11'h001);
        wait_row(1);
        wait_row(0);
        check("active", row_active[31:0], 32'hff);
        check("row0", column_data[31:0], 32'haaaaaaaa);
        check("row0 hi", column_data[63:32], 32'haa);
        cmd(lgs_pkg::OP_DISP, 11'h009);
        wait_row(1);
        wait_row(0);
        check("mirror", column_data[111:80], 32'h55555555);
        cmd(lgs_pkg::OP_DISP, 11'h011);
        wait_row(78);
        wait_row(79);
        check("reverse", column_data[31:0], 32'haaaaaaaa);
        foreach (offs[j]) begin
            cmd(lgs_pkg::OP_DISP, 11'h001);
            wait_row(0);
            cmd(lgs_pkg::OP_DISP, offs[j]);
            repeat (3) @(negedge hclk);
            check("ground", |{row_select, row_active, column_data}, 32'h0);
            check("osc", osc_enable, !offs[j][1]);
        end
        close_out();
    end
endmodule
